// file: design/lockout_pkg.sv
package lockout_pkg;
  // ==========================================================
  // Register map.
  localparam logic [4:0] CTRL_OFFS = 5'h00;
  localparam logic [4:0] EXH_SP_OFFS = 5'h04;
  localparam logic [4:0] STATUS_OFFS = 5'h08;
  localparam logic [4:0] MASK_OFFS = 5'h0C;
  localparam logic [4:0] STATE_OFFS = 5'h10;
  localparam int CTRL_RESET_BIT = 0;
  localparam logic [7:0] EXH_SP_RST = 8'h19;
  localparam logic [7:0] MASK_RST = 8'h00;
  // ==========================================================
  // Timebase: one tick every TICK_MS milliseconds.
  localparam longint CLK_HZ = 100000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = int'(CLK_HZ / 1000 * TICK_MS);
  localparam int FLASH_TICKS = 5;
  localparam int AIRFLOW_S = 40;
  localparam int FILTER_S = 120;
  localparam int OPEN_S = 1;
  localparam int RESTART_S = 180;
  localparam int RUN_WIN_S = 180;
  localparam int TRIP_LIMIT = 4;
  localparam logic [10:0] AIRFLOW_TICKS = 11'(AIRFLOW_S * 1000 / TICK_MS);
  localparam logic [10:0] FILTER_TICKS = 11'(FILTER_S * 1000 / TICK_MS);
  localparam logic [10:0] OPEN_TICKS = 11'(OPEN_S * 1000 / TICK_MS);
  localparam logic [10:0] RESTART_TICKS = 11'(RESTART_S * 1000 / TICK_MS);
  localparam logic [10:0] RUN_WIN_TICKS = 11'(RUN_WIN_S * 1000 / TICK_MS);
  // ==========================================================
  // Event bits shared by the status and mask registers.
  typedef struct packed {
    logic spare;
    logic hp_lock_2;
    logic hp_lock_1;
    logic trip_lock_2;
    logic trip_lock_1;
    logic trip_2;
    logic trip_1;
    logic airflow_lock;
  } event_type;
endpackage : lockout_pkg

// file: design/compressor_safety_lockout_controller.sv
module compressor_safety_lockout_controller #(
  parameter int TICK_CYCLES = lockout_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic zone_sensor_present,
  input wire logic fan_call,
  input wire logic [1:0] cool_call,
  input wire logic airflow_proof_switch,
  input wire logic filter_switch,
  input wire logic [1:0] compressor_disable_inputs,
  input wire logic [1:0] current_sense,
  input wire logic [7:0] damper_pos,
  input wire logic lead_alt_select,
  input wire logic manual_reset,
  output logic supply_fan_out,
  output logic exhaust_fan_out,
  output logic [1:0] compressor_out,
  output logic filter_out,
  output logic service_out,
  output logic irq
);
  // ==========================================================
  // Saturating increment shared by the up-counting airflow, filter, open and run timers.
  function automatic logic [10:0] sat_inc(input logic [10:0] v);
    sat_inc = (v == 11'h7FF) ? v : v + 11'h001;
  endfunction : sat_inc

  logic [31:0] div_reg;
  logic tick;
  logic [2:0] flash_cnt_reg;
  logic flash_reg;
  logic sys_lock_reg;
  logic [10:0] air_cnt_reg;
  logic [10:0] filt_cnt_reg;
  logic [7:0] exh_sp_reg;
  lockout_pkg::event_type status_reg;
  lockout_pkg::event_type mask_reg;
  lockout_pkg::event_type evt;
  logic lead_reg;
  logic [1:0] lock_reg;
  logic [1:0] hp_reg;
  logic [10:0] open_cnt_reg [2];
  logic [10:0] delay_cnt_reg [2];
  logic [10:0] run_cnt_reg [2];
  logic [2:0] trip_cnt_reg [2];
  logic run_en;
  logic reset_req;
  logic air_fail;
  logic filt_on;
  logic [1:0] dem;
  logic [1:0] trip_now;
  logic [1:0] hp_now;
  logic [1:0] lock_now;
  logic [1:0] comp_next;
  logic [1:0] early;
  logic lead_stop;

  // ==========================================================
  // Timebase divider producing a one-cycle tick.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 32'h0;
    end else if (div_reg >= 32'(TICK_CYCLES - 1)) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end
  assign tick = (div_reg >= 32'(TICK_CYCLES - 1));

  // Slow square wave for the flashing service light.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flash_cnt_reg <= 3'h0;
      flash_reg <= 1'b0;
    end else if (tick) begin
      if (flash_cnt_reg == 3'(lockout_pkg::FLASH_TICKS - 1)) begin
        flash_cnt_reg <= 3'h0;
        flash_reg <= ~flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 3'h1;
      end
    end
  end

  // ==========================================================
  // Common enables and per-circuit decisions.
  assign reset_req = manual_reset | (reg_wr && reg_addr == lockout_pkg::CTRL_OFFS &&
                     reg_wdata[lockout_pkg::CTRL_RESET_BIT]);
  assign run_en = zone_sensor_present && !sys_lock_reg;
  assign air_fail = supply_fan_out && !airflow_proof_switch && air_cnt_reg >= lockout_pkg::AIRFLOW_TICKS;
  assign filt_on = supply_fan_out && filter_switch && filt_cnt_reg >= lockout_pkg::FILTER_TICKS;

  // Demand goes to the lead circuit on the first stage, the lag on the second.
  always_comb begin
    dem[0] = lead_reg ? cool_call[1] : cool_call[0];
    dem[1] = lead_reg ? cool_call[0] : cool_call[1];
    for (int i = 0; i < 2; i++) begin
      early[i] = run_cnt_reg[i] < lockout_pkg::RUN_WIN_TICKS;
      trip_now[i] = compressor_out[i] && !compressor_disable_inputs[i] &&
                    open_cnt_reg[i] >= lockout_pkg::OPEN_TICKS;
      hp_now[i] = compressor_out[i] && (|cool_call) && !current_sense[i];
      lock_now[i] = trip_now[i] && early[i] &&
                    trip_cnt_reg[i] == 3'(lockout_pkg::TRIP_LIMIT - 1);
      if (compressor_out[i]) begin
        comp_next[i] = dem[i] && run_en && !lock_reg[i] && !hp_reg[i] && !trip_now[i] && !hp_now[i];
      end else begin
        comp_next[i] = dem[i] && run_en && !lock_reg[i] && !hp_reg[i] &&
                       delay_cnt_reg[i] == 11'h0 && compressor_disable_inputs[i];
      end
    end
    lead_stop = compressor_out[lead_reg] && !dem[lead_reg] && run_en;
  end

  // ==========================================================
  // Airflow proving and the system lockout.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      air_cnt_reg <= 11'h0;
    end else if (!supply_fan_out || airflow_proof_switch) begin
      air_cnt_reg <= 11'h0;
    end else if (tick) begin
      air_cnt_reg <= sat_inc(air_cnt_reg);
    end
  end

  // A lockout that meets a reset in the same cycle stays set.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_lock_reg <= 1'b0;
    end else if (air_fail) begin
      sys_lock_reg <= 1'b1;
    end else if (reset_req) begin
      sys_lock_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Clogged filter timing; it feeds only the indicators.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      filt_cnt_reg <= 11'h0;
    end else if (!supply_fan_out || !filter_switch) begin
      filt_cnt_reg <= 11'h0;
    end else if (tick) begin
      filt_cnt_reg <= sat_inc(filt_cnt_reg);
    end
  end

  // ==========================================================
  // Per-circuit trip, restart delay, run window and lockouts.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_reg <= 2'b00;
      hp_reg <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        open_cnt_reg[i] <= 11'h0;
        delay_cnt_reg[i] <= 11'h0;
        run_cnt_reg[i] <= 11'h0;
        trip_cnt_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!compressor_out[i] || compressor_disable_inputs[i]) begin
          open_cnt_reg[i] <= 11'h0;
        end else if (tick) begin
          open_cnt_reg[i] <= sat_inc(open_cnt_reg[i]);
        end
        if (trip_now[i]) begin
          delay_cnt_reg[i] <= lockout_pkg::RESTART_TICKS;
        end else if (tick && delay_cnt_reg[i] != 11'h0) begin
          delay_cnt_reg[i] <= delay_cnt_reg[i] - 11'h001;
        end
        if (!compressor_out[i] && comp_next[i]) begin
          run_cnt_reg[i] <= 11'h0;
        end else if (compressor_out[i] && tick) begin
          run_cnt_reg[i] <= sat_inc(run_cnt_reg[i]);
        end
        if (trip_now[i]) begin
          trip_cnt_reg[i] <= early[i] ? trip_cnt_reg[i] + 3'h1 : 3'h0;
        end else if (reset_req || (compressor_out[i] && !early[i])) begin
          trip_cnt_reg[i] <= 3'h0;
        end
        if (lock_now[i]) begin
          lock_reg[i] <= 1'b1;
        end else if (reset_req) begin
          lock_reg[i] <= 1'b0;
        end
        if (hp_now[i]) begin
          hp_reg[i] <= 1'b1;
        end else if (reset_req) begin
          hp_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Lead designation, circuit one after every rstn reset; a manual reset keeps it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lead_reg <= 1'b0;
    end else if (lead_alt_select && lead_stop) begin
      lead_reg <= ~lead_reg;
    end
  end

  // ==========================================================
  // Registered outputs; the filter indication gates nothing.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      supply_fan_out <= 1'b0;
      exhaust_fan_out <= 1'b0;
      compressor_out <= 2'b00;
      filter_out <= 1'b0;
      service_out <= 1'b0;
    end else begin
      supply_fan_out <= run_en && !air_fail && (fan_call || (|cool_call));
      exhaust_fan_out <= run_en && !air_fail && supply_fan_out && damper_pos >= exh_sp_reg;
      compressor_out <= (air_fail ? 2'b00 : comp_next);
      filter_out <= filt_on;
      service_out <= sys_lock_reg ? flash_reg : (filt_on || (|lock_reg) || (|hp_reg));
    end
  end

  // ==========================================================
  // Events, sticky status cleared by read, mask and interrupt.
  always_comb begin
    evt = '0;
    evt.airflow_lock = air_fail && !sys_lock_reg;
    evt.trip_1 = trip_now[0];
    evt.trip_2 = trip_now[1];
    evt.trip_lock_1 = lock_now[0] && !lock_reg[0];
    evt.trip_lock_2 = lock_now[1] && !lock_reg[1];
    evt.hp_lock_1 = hp_now[0] && !hp_reg[0];
    evt.hp_lock_2 = hp_now[1] && !hp_reg[1];
  end

  // Status bits stick until a read; an event in the read cycle survives it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= '0;
    end else if (reg_rd && reg_addr == lockout_pkg::STATUS_OFFS) begin
      status_reg <= evt;
    end else begin
      status_reg <= status_reg | evt;
    end
  end

  // The interrupt follows the next status value, so a read never hides a fresh event.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((reg_rd && reg_addr == lockout_pkg::STATUS_OFFS) ? evt : (status_reg | evt)) & mask_reg);
    end
  end

  // ==========================================================
  // Register writes and reads.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      exh_sp_reg <= lockout_pkg::EXH_SP_RST;
      mask_reg <= lockout_pkg::MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == lockout_pkg::EXH_SP_OFFS) begin
        exh_sp_reg <= reg_wdata[7:0];
      end
      if (reg_addr == lockout_pkg::MASK_OFFS) begin
        mask_reg <= reg_wdata[7:0];
      end
    end
  end

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        lockout_pkg::EXH_SP_OFFS: reg_rdata <= {24'h0, exh_sp_reg};
        lockout_pkg::STATUS_OFFS: reg_rdata <= {24'h0, status_reg};
        lockout_pkg::MASK_OFFS: reg_rdata <= {24'h0, mask_reg};
        lockout_pkg::STATE_OFFS: reg_rdata <= {22'h0, compressor_out, filter_out, lead_reg,
                                               hp_reg, lock_reg, sys_lock_reg, lead_alt_select};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Checks.
  property p_air_stop;
    @(posedge core_clk) disable iff (!rstn) sys_lock_reg |=> compressor_out == 2'b00 && !supply_fan_out;
  endproperty
  a_air_stop: assert property (p_air_stop) else $error("Outputs on during system lockout.");

  property p_air_hold;
    @(posedge core_clk) disable iff (!rstn) sys_lock_reg && !reset_req |=> sys_lock_reg;
  endproperty
  a_air_hold: assert property (p_air_hold) else $error("System lockout cleared without reset.");

  property p_filter;
    @(posedge core_clk) disable iff (!rstn) filter_out |-> $past(filter_switch) && $past(supply_fan_out);
  endproperty
  a_filter: assert property (p_filter) else $error("Filter output without closed switch and fan.");

  property p_start;
    @(posedge core_clk) disable iff (!rstn)
      $rose(compressor_out[0]) |-> $past(compressor_disable_inputs[0]) && $past(delay_cnt_reg[0]) == 11'h0;
  endproperty
  a_start: assert property (p_start) else $error("Compressor one started while inhibited.");

  property p_trip;
    @(posedge core_clk) disable iff (!rstn)
      trip_now[0] |=> !compressor_out[0] && delay_cnt_reg[0] == lockout_pkg::RESTART_TICKS;
  endproperty
  a_trip: assert property (p_trip) else $error("Compressor one not stopped and delayed on trip.");

  property p_restart;
    @(posedge core_clk) disable iff (!rstn) !compressor_out[0] && delay_cnt_reg[0] != 11'h0 |=> !compressor_out[0];
  endproperty
  a_restart: assert property (p_restart) else $error("Compressor one restarted inside its delay.");

  property p_lock_hold;
    @(posedge core_clk) disable iff (!rstn) lock_reg[0] && !reset_req |=> lock_reg[0] && !compressor_out[0];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("Circuit one trip lockout lost.");

  property p_hp;
    @(posedge core_clk) disable iff (!rstn) hp_now[1] |=> hp_reg[1] && !compressor_out[1];
  endproperty
  a_hp: assert property (p_hp) else $error("Missing current did not lock circuit two.");

  property p_exhaust;
    @(posedge core_clk) disable iff (!rstn)
      exhaust_fan_out |-> $past(supply_fan_out) && $past(damper_pos) >= $past(exh_sp_reg);
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("Exhaust fan on without fan or damper.");

  property p_zone;
    @(posedge core_clk) disable iff (!rstn) !zone_sensor_present |=> compressor_out == 2'b00 && !supply_fan_out;
  endproperty
  a_zone: assert property (p_zone) else $error("Unit runs without a zone sensor.");

  property p_lead;
    @(posedge core_clk) disable iff (!rstn) !lead_alt_select |=> $stable(lead_reg);
  endproperty
  a_lead: assert property (p_lead) else $error("Lead changed with alternation off.");
endmodule : compressor_safety_lockout_controller

// file: test/rooftop_plant_model.sv
// ==========================================================
// Far side of the controller: pressure switches and contactor current sense.
module rooftop_plant_model (
  input wire logic supply_fan_out,
  input wire logic [1:0] compressor_out,
  input wire logic [1:0] hp_open,
  input wire logic [1:0] lp_open,
  input wire logic belt_broken,
  output logic airflow_proof_switch,
  output logic [1:0] compressor_disable_inputs,
  output logic [1:0] current_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // Airflow is proven only while the fan runs and its belt is intact.
  assign airflow_proof_switch = supply_fan_out & ~belt_broken;
  // Open low pressure contacts read low at the disable inputs.
  assign compressor_disable_inputs = ~lp_open;
  // The series high pressure switch breaks the contactor current at once.
  assign current_sense = compressor_out & ~hp_open;
endmodule : rooftop_plant_model

// file: test/compressor_safety_lockout_controller_tb.sv
// ==========================================================
// Self-checking bench for the safety and lockout controller.
module compressor_safety_lockout_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic zone_sensor_present = 1'b0;
  logic fan_call = 1'b0;
  logic [1:0] cool_call = 2'h0;
  logic filter_switch = 1'b0;
  logic [7:0] damper_pos = 8'h00;
  logic lead_alt_select = 1'b0;
  logic manual_reset = 1'b0;
  logic [1:0] hp_open = 2'h0;
  logic [1:0] lp_open = 2'h0;
  logic belt_broken = 1'b0;
  logic airflow_proof_switch;
  logic [1:0] compressor_disable_inputs;
  logic [1:0] current_sense;
  logic supply_fan_out;
  logic exhaust_fan_out;
  logic [1:0] compressor_out;
  logic filter_out;
  logic service_out;
  logic irq;
  logic [31:0] seed = 32'h6D782580;
  int n_mismatch = 0;
  int n_compared = 0;

  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;

  compressor_safety_lockout_controller #(.TICK_CYCLES(TC)) compressor_safety_lockout_controller_i (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zone_sensor_present(zone_sensor_present),
    .fan_call(fan_call), .cool_call(cool_call), .airflow_proof_switch(airflow_proof_switch),
    .filter_switch(filter_switch), .compressor_disable_inputs(compressor_disable_inputs),
    .current_sense(current_sense), .damper_pos(damper_pos), .lead_alt_select(lead_alt_select),
    .manual_reset(manual_reset), .supply_fan_out(supply_fan_out), .exhaust_fan_out(exhaust_fan_out),
    .compressor_out(compressor_out), .filter_out(filter_out), .service_out(service_out), .irq(irq));

  rooftop_plant_model rooftop_plant_model_i (
    .supply_fan_out(supply_fan_out), .compressor_out(compressor_out), .hp_open(hp_open),
    .lp_open(lp_open), .belt_broken(belt_broken), .airflow_proof_switch(airflow_proof_switch),
    .compressor_disable_inputs(compressor_disable_inputs), .current_sense(current_sense));

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits whole timebase ticks, then lets that edge's updates settle.
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge core_clk);
    #1;
  endtask : ticks

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic pulse_reset();
    @(posedge core_clk);
    manual_reset <= 1'b1;
    @(posedge core_clk);
    manual_reset <= 1'b0;
  endtask : pulse_reset

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // A hang is cut short well after the expected run length.
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    logic [31:0] v;
    int dmp;
    int n_on;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    check("outputs", 32'({supply_fan_out, exhaust_fan_out, compressor_out, filter_out, service_out, irq}), 0);
    rd(lockout_pkg::EXH_SP_OFFS, v);
    check("exh_sp", v, 32'h19);
    rd(lockout_pkg::MASK_OFFS, v);
    check("mask", v, 32'h0);
    rd(lockout_pkg::STATE_OFFS, v);
    check("state", v, 32'h0);
    rd(5'h14, v);
    check("unmapped", v, 32'h0);
    // No sensor present: nothing may run.
    @(posedge core_clk);
    fan_call <= 1'b1;
    cool_call <= 2'b01;
    ticks(5);
    check("idle_no_sensor", 32'({supply_fan_out, compressor_out}), 0);
    @(posedge core_clk);
    zone_sensor_present <= 1'b1;
    ticks(2);
    check("lead_start", 32'({supply_fan_out, compressor_out}), 32'h5);
    // Exhaust against damper, boundary values first, then random positions.
    for (int i = 0; i < 16; i++) begin
      seed = xorshift(seed);
      dmp = (i < 2) ? 24 + i : int'(seed % 101);
      @(posedge core_clk);
      damper_pos <= 8'(dmp);
      ticks(1);
      check("exhaust", 32'(exhaust_fan_out), 32'(dmp >= 25));
    end
    wr(lockout_pkg::EXH_SP_OFFS, 32'h32);
    @(posedge core_clk);
    damper_pos <= 8'h28;
    ticks(1);
    check("exhaust_sp50", 32'(exhaust_fan_out), 0);
    wr(lockout_pkg::EXH_SP_OFFS, 32'h19);
    // Clogged filter needs 1200 unbroken ticks and stops nothing.
    @(posedge core_clk);
    filter_switch <= 1'b1;
    ticks(1195);
    check("filter_early", 32'(filter_out), 0);
    ticks(10);
    check("filter_on", 32'(filter_out), 1);
    check("unit_runs", 32'({supply_fan_out, compressor_out}), 32'h5);
    @(posedge core_clk);
    filter_switch <= 1'b0;
    @(posedge core_clk);
    filter_switch <= 1'b1;
    ticks(1);
    check("filter_break", 32'(filter_out), 0);
    @(posedge core_clk);
    filter_switch <= 1'b0;
    // Open-input trips inside the run window, lockout on the fourth.
    for (int k = 0; k < 5; k++) begin
      @(posedge core_clk);
      lp_open <= 2'b01;
      ticks(8);
      check("comp_before_1s", 32'(compressor_out), 1);
      ticks(4);
      check("comp_after_1s", 32'(compressor_out), 0);
      if (k == 0) begin
        ticks(1818);
      end else begin
        @(posedge core_clk);
        lp_open <= 2'b00;
        ticks(1790);
      end
      check("comp_held_off", 32'(compressor_out), 0);
      @(posedge core_clk);
      lp_open <= 2'b00;
      ticks(k == 3 ? 40 : 14);
      check("comp_restart", 32'(compressor_out), (k == 3) ? 0 : 1);
      if (k == 3) begin
        check("service_lock", 32'({service_out, irq}), 32'h2);
        rd(lockout_pkg::STATUS_OFFS, v);
        check("status_trips", v, 32'h0A);
        pulse_reset();
        ticks(2);
        check("comp_after_reset", 32'(compressor_out), 1);
      end
    end
    // High pressure on circuit two locks only that circuit.
    @(posedge core_clk);
    cool_call <= 2'b11;
    ticks(3);
    check("both_run", 32'(compressor_out), 32'h3);
    @(posedge core_clk);
    hp_open <= 2'b10;
    ticks(3);
    check("hp_lock", 32'(compressor_out), 32'h1);
    @(posedge core_clk);
    hp_open <= 2'b00;
    ticks(10);
    rd(lockout_pkg::STATE_OFFS, v);
    check("hp_state", {30'h0, v[5:4]}, 32'h2);
    check("hp_held", 32'(compressor_out), 32'h1);
    wr(lockout_pkg::CTRL_OFFS, 32'h1);
    ticks(3);
    check("hp_cleared", 32'(compressor_out), 32'h3);
    // Lead alternation: off by jumper, then swapping on satisfied load.
    @(posedge core_clk);
    cool_call <= 2'b00;
    ticks(2);
    rd(lockout_pkg::STATE_OFFS, v);
    check("lead_fixed", 32'(v[6]), 0);
    @(posedge core_clk);
    lead_alt_select <= 1'b1;
    cool_call <= 2'b01;
    ticks(2);
    @(posedge core_clk);
    cool_call <= 2'b00;
    ticks(2);
    rd(lockout_pkg::STATE_OFFS, v);
    check("lead_swapped", 32'(v[6]), 1);
    @(posedge core_clk);
    cool_call <= 2'b01;
    ticks(2);
    check("lead_is_two", 32'(compressor_out), 32'h2);
    // A power-up in mid-run hands the lead back to circuit one.
    @(posedge core_clk);
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    ticks(2);
    check("lead_power_up", 32'(compressor_out), 32'h1);
    // Airflow failure: total stop, latched lockout, flashing service light.
    wr(lockout_pkg::MASK_OFFS, 32'h1);
    @(posedge core_clk);
    damper_pos <= 8'h64;
    belt_broken <= 1'b1;
    ticks(395);
    check("fan_before_limit", 32'({supply_fan_out, exhaust_fan_out}), 32'h3);
    ticks(12);
    check("all_off", 32'({supply_fan_out, exhaust_fan_out, compressor_out}), 0);
    check("irq_raised", 32'(irq), 1);
    n_on = 0;
    for (int i = 0; i < 20; i++) begin
      ticks(1);
      n_on += (service_out === 1'b1) ? 1 : 0;
    end
    check("service_flash", 32'(n_on > 4 && n_on < 16), 1);
    rd(lockout_pkg::STATUS_OFFS, v);
    check("status_airflow", 32'(v[0]), 1);
    ticks(1);
    check("irq_cleared", 32'(irq), 0);
    @(posedge core_clk);
    belt_broken <= 1'b0;
    ticks(20);
    check("still_locked", 32'(supply_fan_out), 0);
    pulse_reset();
    ticks(3);
    check("unlocked", 32'(supply_fan_out), 1);
    stop_test();
  end
endmodule : compressor_safety_lockout_controller_tb
